// ---- rtl/cim_map.svh ----
// Register numbers, field values and timing figures of the cyclic assembly mapper
`ifndef CIM_MAP_SVH
`define CIM_MAP_SVH
`define CIM_SLOTS           8
`define CIM_REG_NONE        32'h0000_0000
`define CIM_REG_MODE        32'h0000_0002
`define CIM_REG_TPOS        32'h0000_0003
`define CIM_REG_VEL         32'h0000_0005
`define CIM_REG_ACC         32'h0000_0006
`define CIM_REG_TRQ         32'h0000_0007
`define CIM_REG_MPOS        32'h0000_000A
`define CIM_REG_MVEL        32'h0000_000C
`define CIM_REG_LOAD        32'h0000_0010
`define CIM_REG_FERR        32'h0000_0014
`define CIM_REG_STAT        32'h0000_0023
`define CIM_MOD_SCALE       32'h0001_0000
`define CIM_MOD_CMD_SUB     32'h0000_000F
`define CIM_REG_CMD         (`CIM_MOD_SCALE * `CIM_MOD_CMD_SUB)
`define CIM_MOTOR_MAX       32'h0000_FFFF
`define CIM_MODE_PASSIVE    32'h0000_0000
`define CIM_MODE_VEL        32'h0000_0001
`define CIM_MODE_POS        32'h0000_0002
`define CIM_WORD_BYTES      4
`define CIM_CLK_MHZ         10
`define CIM_PAIR_PERIOD_US  4000
`define CIM_BASE_PERIOD_US  1000
`define CIM_FIFO_DEPTH      8
`define CIM_GAP_RESET       32'hFFFF_FFFF
`endif

// ---- rtl/cim_pkg.sv ----
// Types shared by the cyclic assembly mapper
package cim_pkg;
   typedef logic [31:0] cim_word_t;                       // One assembly word
   typedef logic [3:0]  cim_len_t;                        // Active slot count 0..8
   typedef enum logic [1:0] {CIM_IDLE, CIM_WRITE, CIM_READ} cim_state_t;
endpackage : cim_pkg

// ---- rtl/cim_word_fifo.sv ----
// Word FIFO holding scanner-to-motor words until the exchange drains them
`timescale 1ns/100ps
`default_nettype none
module cim_word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             nrst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic [WIDTH-1:0]      outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem [DEPTH];          // Storage, no reset needed
   logic [AW-1:0]    wrPtr_ff;             // Next slot to fill
   logic [AW-1:0]    nxt_wrPtr;
   logic [AW-1:0]    rdPtr_ff;             // Oldest word
   logic [AW-1:0]    nxt_rdPtr;
   logic [AW:0]      count_ff;             // Words held
   logic [AW:0]      nxt_count;
   logic             ready_ff;             // Registered room flag
   logic             nxt_ready;
   logic             push;
   logic             pop;

   // Pointer and count update; wrap handles depths that are not powers of two
   always_comb begin
      push      = inValid && ready_ff;
      pop       = outReady && (count_ff != '0);
      nxt_wrPtr = wrPtr_ff;
      nxt_rdPtr = rdPtr_ff;
      nxt_count = count_ff;
      if (push) begin
         nxt_wrPtr = (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (pop) begin
         nxt_rdPtr = (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
      end
      if (push && !pop) begin
         nxt_count = count_ff + 1'b1;
      end else if (pop && !push) begin
         nxt_count = count_ff - 1'b1;
      end
      // Ready is registered so the top drives it straight from a flop
      nxt_ready = (nxt_count != (AW + 1)'(DEPTH));
   end

   // State registers and storage write
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
         ready_ff <= 1'b0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
         ready_ff <= nxt_ready;
      end
      if (push) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   assign inReady  = ready_ff;
   assign outValid = (count_ff != '0);
   assign outData  = mem[rdPtr_ff];
endmodule : cim_word_fifo
`default_nettype wire

// ---- rtl/cim_list_resolver.sv ----
// Resolves the configured cyclic lists into effective lengths and word order
`timescale 1ns/100ps
`default_nettype none
`include "cim_map.svh"
module cim_list_resolver (
   input wire cim_pkg::cim_word_t  rdList   [`CIM_SLOTS],
   input wire cim_pkg::cim_word_t  wrList   [`CIM_SLOTS],
   output cim_pkg::cim_word_t  rdEff    [`CIM_SLOTS],
   output cim_pkg::cim_len_t   rdLen,
   output cim_pkg::cim_len_t   wrLen,
   output cim_pkg::cim_len_t   rdMotor,
   output cim_pkg::cim_len_t   wrMotor
);
   // Module registers sit above the motor range
   function automatic logic isModule(input cim_pkg::cim_word_t num);
      return num > `CIM_MOTOR_MAX;
   endfunction : isModule

   logic rdStop;                            // Empty slot seen in read list
   logic wrStop;                            // Empty slot seen in write list
   logic hasStat;                           // Status word already listed

   // Truncation at the first empty slot, then the forced status word
   always_comb begin
      rdEff   = rdList;
      rdLen   = '0;
      wrLen   = '0;
      rdMotor = '0;
      wrMotor = '0;
      rdStop  = 1'b0;
      wrStop  = 1'b0;
      hasStat = 1'b0;
      for (int i = 0; i < `CIM_SLOTS; i++) begin
         if (rdList[i] == `CIM_REG_NONE) begin
            rdStop = 1'b1;
         end
         if (!rdStop) begin
            rdLen = rdLen + 1'b1;
            // Appended module words cost no cycle time
            if (!isModule(rdList[i])) begin
               rdMotor = rdMotor + 1'b1;
            end
            if (rdList[i] == `CIM_REG_STAT) begin
               hasStat = 1'b1;
            end
         end
         if (wrList[i] == `CIM_REG_NONE) begin
            wrStop = 1'b1;
         end
         if (!wrStop) begin
            wrLen = wrLen + 1'b1;
            if (!isModule(wrList[i])) begin
               wrMotor = wrMotor + 1'b1;
            end
         end
      end
      // Status is mandatory; a full list loses its last word to it
      if (!hasStat) begin
         if (rdLen < cim_pkg::cim_len_t'(`CIM_SLOTS)) begin
            rdEff[rdLen[2:0]] = `CIM_REG_STAT;
            rdLen             = rdLen + 1'b1;
            rdMotor           = rdMotor + 1'b1;
         end else begin
            if (isModule(rdList[`CIM_SLOTS-1])) begin
               rdMotor = rdMotor + 1'b1;
            end
            rdEff[`CIM_SLOTS-1] = `CIM_REG_STAT;
         end
      end
   end
endmodule : cim_list_resolver
`default_nettype wire

// ---- rtl/cim_assembly_mapper.sv ----
// Cyclic I/O assembly mapper: list configuration, exchange sequencing, motor registers
`timescale 1ns/100ps
`default_nettype none
`include "cim_map.svh"
module cim_assembly_mapper #(
   parameter bit SMALL_VARIANT = 1'b1,
   parameter int PAIR_CYCLES   = `CIM_PAIR_PERIOD_US * `CIM_CLK_MHZ,
   parameter int BASE_CYCLES   = `CIM_BASE_PERIOD_US * `CIM_CLK_MHZ
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         cfgWrite,
   input  wire logic         cfgOutList,
   input  wire logic [2:0]   cfgSlot,
   input wire cim_pkg::cim_word_t cfgRegNum,
   input  wire logic         cycRequest,
   input wire cim_pkg::cim_word_t outWordData,
   input  wire logic         outWordValid,
   output logic              outWordReady,
   output cim_pkg::cim_word_t inWordData,
   output logic              inWordValid,
   output logic              inWordLast,
   input  wire logic         inWordReady,
   output logic              cycDone,
   output logic              cycDropped,
   output logic [5:0]        inputBytes,
   output logic [5:0]        outputBytes,
   input wire cim_pkg::cim_word_t measPos,
   input wire cim_pkg::cim_word_t measVel,
   input wire cim_pkg::cim_word_t meanLoad,
   input wire cim_pkg::cim_word_t followErr,
   input wire cim_pkg::cim_word_t faultFlags,
   output logic              motorActive,
   output logic              velocityMode,
   output logic              positionMode,
   output cim_pkg::cim_word_t motionTarget,
   output cim_pkg::cim_word_t velocitySetpoint,
   output cim_pkg::cim_word_t accelSetpoint,
   output cim_pkg::cim_word_t torqueLimit,
   output logic              cmdValid,
   output cim_pkg::cim_word_t cmdWord
);
   localparam int SLOTS = `CIM_SLOTS;

   // List configuration (scanner view: read = input, write = output)
   cim_pkg::cim_word_t rdCfg_ff  [SLOTS];  // Motor-to-scanner selections
   cim_pkg::cim_word_t nxt_rdCfg [SLOTS];
   cim_pkg::cim_word_t wrCfg_ff  [SLOTS];  // Scanner-to-motor selections
   cim_pkg::cim_word_t nxt_wrCfg [SLOTS];
   cim_pkg::cim_word_t rdEff     [SLOTS];  // Read list after status insert
   cim_pkg::cim_len_t  rdLen;
   cim_pkg::cim_len_t  wrLen;
   cim_pkg::cim_len_t  rdMotor;
   cim_pkg::cim_len_t  wrMotor;

   // Exchange sequencing
   cim_pkg::cim_state_t state_ff;          // Exchange phase
   cim_pkg::cim_state_t nxt_state;
   cim_pkg::cim_len_t   slot_ff;           // Current list position
   cim_pkg::cim_len_t   nxt_slot;
   logic                discard_ff;        // Request came too early
   logic                nxt_discard;
   logic [31:0]         gap_ff;            // Cycles since last accepted request
   logic [31:0]         nxt_gap;
   logic [31:0]         minGap;            // Required spacing for this list
   cim_pkg::cim_len_t   pairs;
   logic                tooEarly;

   // Motor and module registers
   cim_pkg::cim_word_t mode_ff, nxt_mode;
   cim_pkg::cim_word_t tpos_ff, nxt_tpos;
   cim_pkg::cim_word_t vel_ff, nxt_vel;
   cim_pkg::cim_word_t acc_ff, nxt_acc;
   cim_pkg::cim_word_t trq_ff, nxt_trq;
   cim_pkg::cim_word_t target_ff, nxt_target;
   cim_pkg::cim_word_t cmd_ff, nxt_cmd;
   logic               cmdValid_ff, nxt_cmdValid;
   logic               active_ff, nxt_active;
   logic               velMode_ff, nxt_velMode;
   logic               posMode_ff, nxt_posMode;

   // Input word stream and status pulses
   cim_pkg::cim_word_t inData_ff, nxt_inData;
   logic               inValid_ff, nxt_inValid;
   logic               inLast_ff, nxt_inLast;
   logic               done_ff, nxt_done;
   logic               drop_ff, nxt_drop;
   logic [5:0]         inBytes_ff, nxt_inBytes;
   logic [5:0]         outBytes_ff, nxt_outBytes;

   // FIFO drain side
   cim_pkg::cim_word_t fifoData;
   logic               fifoValid;
   logic               fifoPop;
   logic               fifoReady;
   cim_pkg::cim_word_t wrNum;              // Register of the current write slot
   cim_pkg::cim_word_t rdNum;              // Register of the current read slot
   cim_pkg::cim_word_t rdValue;

   // Assembly byte count, every word taking four bytes
   function automatic logic [5:0] toBytes(input cim_pkg::cim_len_t len);
      return 6'(len * `CIM_WORD_BYTES);
   endfunction : toBytes

   cim_list_resolver u_resolver (
      .rdList  (rdCfg_ff),
      .wrList  (wrCfg_ff),
      .rdEff   (rdEff),
      .rdLen   (rdLen),
      .wrLen   (wrLen),
      .rdMotor (rdMotor),
      .wrMotor (wrMotor)
   );

   // Output words wait here; only the write phase drains, so it can fill
   cim_word_fifo #(
      .WIDTH (32),
      .DEPTH (`CIM_FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .nrst     (nrst),
      .inData   (outWordData),
      .inValid  (outWordValid),
      .inReady  (fifoReady),
      .outData  (fifoData),
      .outValid (fifoValid),
      .outReady (fifoPop)
   );

   // Read mux over the motor register map
   always_comb begin
      rdNum = rdEff[slot_ff[2:0]];
      wrNum = wrCfg_ff[slot_ff[2:0]];
      if (rdNum == `CIM_REG_MODE) begin
         rdValue = mode_ff;
      end else if (rdNum == `CIM_REG_TPOS) begin
         rdValue = tpos_ff;
      end else if (rdNum == `CIM_REG_VEL) begin
         rdValue = vel_ff;
      end else if (rdNum == `CIM_REG_ACC) begin
         rdValue = acc_ff;
      end else if (rdNum == `CIM_REG_TRQ) begin
         rdValue = trq_ff;
      end else if (rdNum == `CIM_REG_MPOS) begin
         rdValue = measPos;
      end else if (rdNum == `CIM_REG_MVEL) begin
         rdValue = measVel;
      end else if (rdNum == `CIM_REG_LOAD) begin
         rdValue = meanLoad;
      end else if (rdNum == `CIM_REG_FERR) begin
         rdValue = followErr;
      end else if (rdNum == `CIM_REG_STAT) begin
         rdValue = faultFlags;
      end else begin
         rdValue = `CIM_REG_NONE;           // Unmapped and write-only read zero
      end
   end

   // Spacing check: small variant scales with motor pairs
   always_comb begin
      pairs    = (rdMotor > wrMotor) ? rdMotor : wrMotor;
      minGap   = SMALL_VARIANT ? 32'(PAIR_CYCLES) * 32'(pairs)
                               : 32'(BASE_CYCLES);
      tooEarly = (gap_ff < minGap);
   end

   // Exchange sequencer, list configuration and register writes
   always_comb begin
      nxt_rdCfg    = rdCfg_ff;
      nxt_wrCfg    = wrCfg_ff;
      nxt_state    = state_ff;
      nxt_slot     = slot_ff;
      nxt_discard  = discard_ff;
      nxt_gap      = (gap_ff == `CIM_GAP_RESET) ? gap_ff : gap_ff + 32'h0000_0001;
      nxt_mode     = mode_ff;
      nxt_tpos     = tpos_ff;
      nxt_vel      = vel_ff;
      nxt_acc      = acc_ff;
      nxt_trq      = trq_ff;
      nxt_cmd      = cmd_ff;
      nxt_cmdValid = 1'b0;
      nxt_inData   = inData_ff;
      nxt_inValid  = inValid_ff;
      nxt_inLast   = inLast_ff;
      nxt_done     = 1'b0;
      nxt_drop     = 1'b0;
      fifoPop      = 1'b0;
      case (state_ff)
         cim_pkg::CIM_IDLE: begin
            // Lists change only between exchanges so a frame stays coherent
            if (cfgWrite && cfgOutList) begin
               nxt_wrCfg[cfgSlot] = cfgRegNum;
            end else if (cfgWrite) begin
               nxt_rdCfg[cfgSlot] = cfgRegNum;
            end
            if (cycRequest) begin
               nxt_discard = tooEarly;
               nxt_slot    = '0;
               if (!tooEarly) begin
                  nxt_gap = 32'h0000_0000;
               end
               if (wrLen != '0) begin
                  nxt_state = cim_pkg::CIM_WRITE;
               end else if (tooEarly) begin
                  nxt_drop = 1'b1;
               end else begin
                  nxt_state = cim_pkg::CIM_READ;
               end
            end
         end
         cim_pkg::CIM_WRITE: begin
            // Words arrive in slot order; a dropped request still eats them
            fifoPop = fifoValid;
            if (fifoValid && !discard_ff) begin
               if (wrNum == `CIM_REG_MODE) begin
                  nxt_mode = fifoData;
               end else if (wrNum == `CIM_REG_TPOS) begin
                  nxt_tpos = fifoData;
               end else if (wrNum == `CIM_REG_VEL) begin
                  nxt_vel = fifoData;
               end else if (wrNum == `CIM_REG_ACC) begin
                  nxt_acc = fifoData;
               end else if (wrNum == `CIM_REG_TRQ) begin
                  nxt_trq = fifoData;
               end else if (wrNum == `CIM_REG_CMD) begin
                  nxt_cmd      = fifoData;
                  nxt_cmdValid = 1'b1;
               end
               // Status and other protected numbers are ignored on write
            end
            if (fifoValid) begin
               nxt_slot = slot_ff + 1'b1;
               if (slot_ff == wrLen - 1'b1) begin
                  nxt_slot = '0;
                  if (discard_ff) begin
                     nxt_state = cim_pkg::CIM_IDLE;
                     nxt_drop  = 1'b1;
                  end else begin
                     nxt_state = cim_pkg::CIM_READ;
                  end
               end
            end
         end
         cim_pkg::CIM_READ: begin
            // Input words leave one per handshake, slot zero first
            if (inValid_ff && inWordReady && inLast_ff) begin
               nxt_inValid = 1'b0;
               nxt_inLast  = 1'b0;
               nxt_state   = cim_pkg::CIM_IDLE;
               nxt_done    = 1'b1;
            end else if (!inValid_ff || inWordReady) begin
               nxt_inData  = rdValue;
               nxt_inValid = 1'b1;
               nxt_inLast  = (slot_ff == rdLen - 1'b1);
               nxt_slot    = slot_ff + 1'b1;
            end
         end
         default: begin
            nxt_state = cim_pkg::CIM_IDLE;
         end
      endcase
      // Mode decode; any nonzero mode wakes the motor
      nxt_active   = (nxt_mode != `CIM_MODE_PASSIVE);
      nxt_velMode  = (nxt_mode == `CIM_MODE_VEL);
      nxt_posMode  = (nxt_mode == `CIM_MODE_POS);
      // Target follows the request only in position mode, else holds
      nxt_target   = nxt_posMode ? nxt_tpos : target_ff;
      nxt_inBytes  = toBytes(rdLen);
      nxt_outBytes = toBytes(wrLen);
   end

   // State registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < SLOTS; i++) begin
            rdCfg_ff[i] <= `CIM_REG_NONE;
            wrCfg_ff[i] <= `CIM_REG_NONE;
         end
         state_ff    <= cim_pkg::CIM_IDLE;
         slot_ff     <= '0;
         discard_ff  <= 1'b0;
         gap_ff      <= `CIM_GAP_RESET;     // First request is always in time
         mode_ff     <= `CIM_MODE_PASSIVE;
         tpos_ff     <= 32'h0000_0000;
         vel_ff      <= 32'h0000_0000;
         acc_ff      <= 32'h0000_0000;
         trq_ff      <= 32'h0000_0000;
         target_ff   <= 32'h0000_0000;
         cmd_ff      <= 32'h0000_0000;
         cmdValid_ff <= 1'b0;
         active_ff   <= 1'b0;
         velMode_ff  <= 1'b0;
         posMode_ff  <= 1'b0;
         inData_ff   <= 32'h0000_0000;
         inValid_ff  <= 1'b0;
         inLast_ff   <= 1'b0;
         done_ff     <= 1'b0;
         drop_ff     <= 1'b0;
         inBytes_ff  <= 6'h00;
         outBytes_ff <= 6'h00;
      end else begin
         rdCfg_ff    <= nxt_rdCfg;
         wrCfg_ff    <= nxt_wrCfg;
         state_ff    <= nxt_state;
         slot_ff     <= nxt_slot;
         discard_ff  <= nxt_discard;
         gap_ff      <= nxt_gap;
         mode_ff     <= nxt_mode;
         tpos_ff     <= nxt_tpos;
         vel_ff      <= nxt_vel;
         acc_ff      <= nxt_acc;
         trq_ff      <= nxt_trq;
         target_ff   <= nxt_target;
         cmd_ff      <= nxt_cmd;
         cmdValid_ff <= nxt_cmdValid;
         active_ff   <= nxt_active;
         velMode_ff  <= nxt_velMode;
         posMode_ff  <= nxt_posMode;
         inData_ff   <= nxt_inData;
         inValid_ff  <= nxt_inValid;
         inLast_ff   <= nxt_inLast;
         done_ff     <= nxt_done;
         drop_ff     <= nxt_drop;
         inBytes_ff  <= nxt_inBytes;
         outBytes_ff <= nxt_outBytes;
      end
   end

   assign outWordReady     = fifoReady;
   assign inWordData       = inData_ff;
   assign inWordValid      = inValid_ff;
   assign inWordLast       = inLast_ff;
   assign cycDone          = done_ff;
   assign cycDropped       = drop_ff;
   assign inputBytes       = inBytes_ff;
   assign outputBytes      = outBytes_ff;
   assign motorActive      = active_ff;
   assign velocityMode     = velMode_ff;
   assign positionMode     = posMode_ff;
   assign motionTarget     = target_ff;
   assign velocitySetpoint = vel_ff;
   assign accelSetpoint    = acc_ff;
   assign torqueLimit      = trq_ff;
   assign cmdValid         = cmdValid_ff;
   assign cmdWord          = cmd_ff;
endmodule : cim_assembly_mapper
`default_nettype wire

// ---- tb/cim_assembly_mapper_chk.sv ----
// Port checks for the cyclic assembly mapper
`timescale 1ns/100ps
`default_nettype none
module cim_assembly_mapper_chk (
   input wire logic               clk,
   input wire logic               nrst,
   input wire logic               cycRequest,
   input wire cim_pkg::cim_word_t inWordData,
   input wire logic               inWordValid,
   input wire logic               inWordLast,
   input wire logic               inWordReady,
   input wire logic               cycDone,
   input wire logic               cycDropped,
   input wire logic [5:0]         inputBytes,
   input wire logic [5:0]         outputBytes,
   input wire logic               motorActive,
   input wire logic               velocityMode,
   input wire logic               positionMode,
   input wire cim_pkg::cim_word_t motionTarget
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Last input word taken
   sequence lastTaken; inWordValid && inWordLast && inWordReady; endsequence
   // Ends of an exchange, either way
   sequence cycEnd; cycDone || cycDropped; endsequence
   chk_status_forced: assert property ($past(nrst, 3) |-> inputBytes >= 6'h04 &&
      inputBytes <= 6'h20 && inputBytes[1:0] == 2'h0) else $error("input size off");
   chk_out_words: assert property (outputBytes[1:0] == 2'h0 && outputBytes <= 6'h20)
      else $error("output size off");
   chk_done_last: assert property (lastTaken |=> cycDone) else $error("no done");
   chk_word_hold: assert property (inWordValid && !inWordReady |=> inWordValid &&
      $stable(inWordData) && $stable(inWordLast)) else $error("word not held");
   chk_mode_flags: assert property (velocityMode || positionMode |-> motorActive &&
      !(velocityMode && positionMode)) else $error("mode flags off");
   chk_target_hold: assert property (!positionMode && !$past(positionMode) |->
      $stable(motionTarget)) else $error("target moved");
   chk_drop_quiet: assert property (cycDropped |-> !inWordValid ##1 !inWordValid)
      else $error("drop sent data");
   chk_end_bound: assert property (cycRequest |-> ##[1:200] cycEnd) else $error("no end");
   chk_end_pulse: assert property (cycEnd |=> !cycDone && !cycDropped) else $error("long");
endmodule : cim_assembly_mapper_chk
`default_nettype wire

// ---- tb/cim_scanner_model.sv ----
// Scanner side model: takes input words, may stall, keeps them
`timescale 1ns/100ps
`default_nettype none
module cim_scanner_model (
   input wire logic               clk,
   input wire logic               slow,
   input wire logic               clear,
   input wire cim_pkg::cim_word_t inWordData,
   input wire logic               inWordValid,
   output var logic               inWordReady
);
   cim_pkg::cim_word_t got [8];   // Words of this exchange
   logic [3:0]         gotCount;  // How many arrived
   initial inWordReady = 1'b0;
   // Slow mode stalls every other cycle to test holding
   always @(posedge clk) begin
      inWordReady <= slow ? !inWordReady : 1'b1;
      if (clear) gotCount <= 4'h0;
      else if (inWordValid && inWordReady) begin
         got[gotCount[2:0]] <= inWordData;
         gotCount <= gotCount + 4'h1;
      end
   end
endmodule : cim_scanner_model
`default_nettype wire

// ---- tb/cim_assembly_mapper_bench.sv ----
// Self-checking bench for the cyclic assembly mapper
`timescale 1ns/100ps
`default_nettype none
module cim_assembly_mapper_bench;
   logic clk, nrst, cfgWrite, cfgOutList, cycRequest, outWordValid, slow, clear;
   logic outWordReady, inWordValid, inWordLast, inWordReady, cycDone, cycDropped, cmdValid;
   logic motorActive, velocityMode, positionMode, sawDone, sawDrop, sawCmd;
   logic [2:0] cfgSlot;
   logic [5:0] inputBytes, outputBytes;
   cim_pkg::cim_word_t cfgRegNum, outWordData, inWordData, motionTarget, cmdWord;
   cim_pkg::cim_word_t velocitySetpoint, accelSetpoint, torqueLimit;
   int fail_count = 0, check_count = 0;
   // Short periods: 20 cycles per motor pair
   cim_assembly_mapper #(.SMALL_VARIANT(1'b1), .PAIR_CYCLES(20), .BASE_CYCLES(5)) i_dut (
      .clk, .nrst, .cfgWrite, .cfgOutList, .cfgSlot, .cfgRegNum, .cycRequest, .outWordData,
      .outWordValid, .outWordReady, .inWordData, .inWordValid, .inWordLast, .inWordReady,
      .cycDone, .cycDropped, .inputBytes, .outputBytes, .measPos(motionTarget),
      .measVel(velocitySetpoint), .meanLoad(torqueLimit), .followErr(32'h0000_1414),
      .faultFlags(32'h0000_2323), .motorActive, .velocityMode, .positionMode, .motionTarget,
      .velocitySetpoint, .accelSetpoint, .torqueLimit, .cmdValid, .cmdWord);
   cim_scanner_model i_scn (.clk, .slow, .clear, .inWordData, .inWordValid, .inWordReady);
   task automatic chk(string what, cim_pkg::cim_word_t exp, cim_pkg::cim_word_t got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Writes all eight slots of one list
   task automatic setList(logic ol, cim_pkg::cim_word_t l [8]);
      for (int k = 0; k < 8; k++) begin
         cfgOutList <= ol;
         cfgSlot <= 3'(k);
         cfgRegNum <= l[k];
         cfgWrite <= 1'b1;
         @(posedge clk);
      end
      cfgWrite <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : setList
   task automatic push(cim_pkg::cim_word_t w [$]);
      int n;
      outWordValid <= 1'b1;
      foreach (w[k]) begin
         outWordData <= w[k];
         n = 0;
         do begin @(posedge clk); n++; end while (!outWordReady && n < 50);
         if (n >= 50) finish_test(1'b1);
      end
      outWordValid <= 1'b0;
   endtask : push
   // One exchange, noting how it ended
   task automatic cyc();
      clear <= 1'b1;
      cycRequest <= 1'b1;
      @(posedge clk);
      clear <= 1'b0;
      cycRequest <= 1'b0;
      {sawDone, sawDrop, sawCmd} = 3'h0;
      for (int n = 0; n < 300 && !(sawDone || sawDrop); n++) begin
         @(posedge clk);
         sawDone |= cycDone;
         sawDrop |= cycDropped;
         sawCmd |= cmdValid;
      end
      if (!(sawDone || sawDrop)) finish_test(1'b1);
      @(posedge clk);
   endtask : cyc
   task automatic finish_test(bit late);
      fail_count += late;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      finish_test(1'b1);
   end
   initial begin
      {nrst, cfgWrite, cfgOutList, cfgSlot, cfgRegNum, cycRequest} = '0;
      {outWordData, outWordValid, slow, clear} = '0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      chk("inputBytes", 32'h0000_0004, 32'(inputBytes));
      setList(1'b0, '{0: 32'h0000_000A, 1: 32'h0000_000C, 3: 32'h0000_0010, default: '0});
      setList(1'b1, '{0: 32'h0000_0002, 1: 32'h0000_0003, 2: 32'h0000_0005, default: '0});
      chk("inputBytes", 32'h0000_000C, 32'(inputBytes));
      chk("outputBytes", 32'h0000_000C, 32'(outputBytes));
      slow <= 1'b1;
      push('{32'h0000_0002, 32'h0000_1234, 32'h0000_0055});
      cyc();
      chk("words", 32'h0000_0003, 32'(i_scn.gotCount));
      chk("word0", 32'h0000_1234, i_scn.got[0]);
      chk("word1", 32'h0000_0055, i_scn.got[1]);
      chk("word2", 32'h0000_2323, i_scn.got[2]);
      chk("posMode", 32'h0000_0001, 32'(positionMode && motorActive));
      chk("target", 32'h0000_1234, motionTarget);
      chk("velocity", 32'h0000_0055, velocitySetpoint);
      $display("basic exchange done");
      push('{32'h0000_0002, 32'h0000_9999, 32'h0000_0077});
      cyc();
      chk("dropped", 32'h0000_0001, 32'(sawDrop));
      chk("dropWords", 32'h0000_0000, 32'(i_scn.gotCount));
      chk("velocity", 32'h0000_0055, velocitySetpoint);
      $display("early request done");
      setList(1'b0, '{32'h0000_000A, 32'h0000_000C, 32'h0000_0010, 32'h0000_0014,
         32'h0000_000A, 32'h0000_000C, 32'h0000_0010, 32'h0000_0014});
      setList(1'b1, '{0: 32'h0000_0002, 1: 32'h0000_0003, 2: 32'h000F_0000, default: '0});
      chk("inputBytes", 32'h0000_0020, 32'(inputBytes));
      slow <= 1'b0;
      repeat (200) @(posedge clk);
      push('{32'h0000_0001, 32'h0000_5678, 32'h0000_0003});
      cyc();
      chk("words", 32'h0000_0008, 32'(i_scn.gotCount));
      chk("lastWord", 32'h0000_2323, i_scn.got[7]);
      chk("velMode", 32'h0000_0001, 32'(velocityMode && !positionMode));
      chk("target", 32'h0000_1234, motionTarget);
      chk("cmdSeen", 32'h0000_0001, 32'(sawCmd));
      chk("cmdWord", 32'h0000_0003, cmdWord);
      $display("full list done");
      setList(1'b1, '{0: 32'h0000_0002, default: '0});
      repeat (200) @(posedge clk);
      push('{32'h0000_0000});
      cyc();
      chk("passive", 32'h0000_0000, 32'(motorActive));
      $display("passive mode done");
      finish_test(1'b0);
   end
endmodule : cim_assembly_mapper_bench
bind cim_assembly_mapper cim_assembly_mapper_chk i_chk (.clk, .nrst, .cycRequest, .inWordData,
   .inWordValid, .inWordLast, .inWordReady, .cycDone, .cycDropped, .inputBytes, .outputBytes,
   .motorActive, .velocityMode, .positionMode, .motionTarget);
`default_nettype wire
